// [core/sacs_regs.vh]
`ifndef SACS_REGS_VH
`define SACS_REGS_VH

// Register word indexes on the Avalon-MM address port
`define SACS_IDX_CONTROL_REGISTER_A     4'h0
`define SACS_IDX_CONTROL_REGISTER_C     4'h1
`define SACS_IDX_CONTROL_REGISTER_D     4'h2
`define SACS_IDX_SAMPLE_CONTROL_REGISTER  4'h3
`define SACS_IDX_CHANSEL   4'h4
`define SACS_IDX_COMMAND   4'h5
`define SACS_IDX_EVENT_CONTROL_REGISTER    4'h6
`define SACS_IDX_INTEN     4'h7
`define SACS_IDX_INTERRUPT_FLAGS_REGISTER  4'h8
`define SACS_IDX_RESULT    4'h9
`define SACS_IDX_STATUS    4'ha

// Control register a
`define SACS_ENABLE_BIT    0
`define SACS_FREERUN_BIT   1
// Control register c
`define SACS_CLOCK_DIVIDER_SELECT_LSB     0
`define SACS_CLOCK_DIVIDER_SELECT_MSB     2
`define SACS_REFERENCE_SELECT_LSB    4
`define SACS_REFERENCE_SELECT_MSB    5
// Sample delay and sample length fields
`define SACS_SDLY_MSB      3
`define SACS_SLEN_MSB      4
// Channel select
`define SACS_CHAN_MSB      3
// Single-bit registers
`define SACS_START_BIT     0
`define SACS_START_EVENT_INPUT_ENABLE_BIT   0
`define SACS_RDYEN_BIT     0
`define SACS_RDY_BIT       0
// Status register
`define SACS_ST_CONV_BIT   0
`define SACS_ST_ACHAN_LSB  4
`define SACS_ST_AREF_LSB   8

// Conversion timing in converter-clock cycles, and the first trial-code mask
`define SACS_SAMPLE_BASE   6'h02
`define SACS_NORMAL_CYC    6'h0d
`define SACS_SAR_MSB_MASK  10'h200

// Reset values
`define SACS_RST_CLOCK_DIVIDER_SELECT     3'h0
`define SACS_RST_REFERENCE_SELECT    2'h0
`define SACS_RST_CHAN      4'h0
`define SACS_RST_WORD      32'h0000_0000

`endif

// [core/sacs_seq.v]
// Functional notes
// R1 - Writing start bit begins conversion; bit reads 1 while converting
// R2 - Single mode: hardware clears start bit when conversion completes
// R3 - Channel change mid-conversion takes effect only after that conversion
// R4 - Finished conversion sets result-ready flag
// R5 - Interrupt request only with flag, enable bit and global enable set
// R6 - Flag sets on completion even with interrupt disabled
// R7 - With event input enabled, each event triggers a conversion
// R8 - Event is edge sensitive, sets start bit, cleared on completion
// R9 - Free-running: first start by write, then back-to-back conversions, each flags
// R10 - Prescaler divides clock; runs while enabled, counter zero when disabled
// R11 - Prescaler held reset when idle; start at next converter-clock rising edge
// R12 - Normal conversion lasts 13 converter-clock cycles
// R13 - Sample-and-hold two converter cycles after start, before added delays
// R14 - Result stored on completion; flag cleared by result read or write-1
// R15 - Sampling period is 2 plus sample delay plus sample length
// R16 - Channel and reference buffered; active copies follow until start
// R17 - Active selections frozen during conversion; follow again in last cycle
// R18 - Software selects channel before start, changes it one cycle later at earliest
// R19 - Input above reference yields 0x3ff
// R20 - Reference select chooses supply or internal reference
// R21 - Software keeps converter clock between 50 kHz and 1.5 MHz
// R22 - Selections have no effect until converter is enabled
// R23 - 10-bit result right adjusted in result register
// R24 - Writing 0 does nothing; writing 1 while converting does not restart
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "sacs_regs.vh"

module sacs_seq #(
  parameter RES_W  = 10,
  parameter CHAN_W = 4,
  parameter REF_W  = 2,
  parameter SDLY_W = 4,
  parameter SLEN_W = 5
) (
  input  wire              clk,
  input  wire              nrst,
  input  wire              ce,
  input  wire [3:0]        address,
  input  wire              read,
  input  wire              write,
  input  wire [31:0]       writedata,
  output reg  [31:0]       readdata,
  output reg               waitrequest,
  input  wire              event_in,
  input  wire              global_int_en,
  input  wire              cmp_in,
  output reg               irq,
  output reg               conv_clk,
  output reg               sample_track,
  output reg  [RES_W-1:0]  dac_code,
  output reg  [CHAN_W-1:0] chan_active,
  output reg  [REF_W-1:0]  ref_active
);

  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_WAIT = 2'h1;
  localparam [1:0] S_CONV = 2'h2;

  reg               enable_ff;
  reg               freerun_ff;
  reg  [2:0]        clock_divider_select_ff;
  reg  [REF_W-1:0]  ref_buf_ff;
  reg  [CHAN_W-1:0] chan_buf_ff;
  reg  [SDLY_W-1:0] sdly_ff;
  reg  [SLEN_W-1:0] slen_ff;
  reg               start_event_input_enable_ff;
  reg               rdy_en_ff;
  reg               rdy_ff;
  reg               start_ff;
  reg  [RES_W-1:0]  result_ff;
  reg  [1:0]        state_ff;
  reg  [7:0]        div_cnt_ff;
  reg  [5:0]        cyc_ff;
  reg  [RES_W-1:0]  mask_ff;
  reg               event_prev_ff;

  reg  [1:0]        nxt_state;
  reg  [31:0]       nxt_rdata;

  wire              acc_ok;
  wire              wr_acc;
  wire              rd_acc;
  wire [7:0]        half_m1;
  wire [7:0]        full_m1;
  wire              div_run;
  wire              tick;
  wire [5:0]        samp_end;
  wire [5:0]        last_cyc;
  wire              in_conv;
  wire              done;
  wire              sw_start;
  wire              ev_start;
  wire              accept;
  wire              lock_sel;
  wire              bit_step;
  wire              rdy_clr;

  // Bus access completes on the edge where the master sees waitrequest low
  assign acc_ok = ce & ~waitrequest;
  assign wr_acc = acc_ok & write;
  assign rd_acc = acc_ok & read;

  // R10 division factor is 2 << clock_divider_select, so half a period is 1 << clock_divider_select
  assign half_m1 = (8'h01 << clock_divider_select_ff) - 8'h01;
  assign full_m1 = {half_m1[6:0], 1'b1};

  // R11 prescaler only runs while a conversion is pending or ongoing
  assign div_run = enable_ff & (state_ff != S_IDLE);
  // R11 converter-clock rising edge
  assign tick = div_run & (div_cnt_ff == half_m1);

  // R15 sampling spans 2 + delay + length converter cycles
  assign samp_end = `SACS_SAMPLE_BASE + {{(6-SDLY_W){1'b0}}, sdly_ff}
                  + {{(6-SLEN_W){1'b0}}, slen_ff};
  // R12 13 cycles plus any added delay and length
  assign last_cyc = samp_end + (`SACS_NORMAL_CYC - `SACS_SAMPLE_BASE) - 6'h01;

  assign in_conv = (state_ff == S_CONV);
  assign done    = in_conv & tick & (cyc_ff == last_cyc);
  assign bit_step = in_conv & tick & (cyc_ff >= samp_end) & (mask_ff != {RES_W{1'b0}});

  // R24 only a written 1 counts
  assign sw_start = wr_acc & (address == `SACS_IDX_COMMAND)
                  & writedata[`SACS_START_BIT];
  // R7 edge-sensitive event trigger
  assign ev_start = start_event_input_enable_ff & event_in & ~event_prev_ff;
  // R24 a trigger during a running conversion is ignored; one on the completing
  // converter-clock edge is taken, so a set arriving with the clear is not lost
  assign accept = enable_ff & (sw_start | ev_start) & (~start_ff | done);

  // R17 frozen from start until the last converter cycle
  assign lock_sel = in_conv & (cyc_ff != last_cyc);

  // R14 result read or write-one clears the flag
  assign rdy_clr = (rd_acc & (address == `SACS_IDX_RESULT))
                 | (wr_acc & (address == `SACS_IDX_INTERRUPT_FLAGS_REGISTER)
                    & writedata[`SACS_RDY_BIT]);

  always @* begin
    nxt_state = state_ff;
    if (!enable_ff) begin
      nxt_state = S_IDLE;
    end else begin
      case (state_ff)
        S_IDLE: begin
          if (accept) begin
            nxt_state = S_WAIT;
          end
        end
        S_WAIT: begin
          // R11 conversion begins at the next converter-clock edge
          if (tick) begin
            nxt_state = S_CONV;
          end
        end
        S_CONV: begin
          if (done) begin
            // R9 free-running restarts at once
            if (freerun_ff || accept) begin
              nxt_state = S_CONV;
            end else begin
              nxt_state = S_IDLE;
            end
          end
        end
        default: begin
          nxt_state = S_IDLE;
        end
      endcase
    end
  end

  always @* begin
    nxt_rdata = `SACS_RST_WORD;
    case (address)
      `SACS_IDX_CONTROL_REGISTER_A: begin
        nxt_rdata[`SACS_ENABLE_BIT]  = enable_ff;
        nxt_rdata[`SACS_FREERUN_BIT] = freerun_ff;
      end
      `SACS_IDX_CONTROL_REGISTER_C: begin
        nxt_rdata[`SACS_CLOCK_DIVIDER_SELECT_MSB:`SACS_CLOCK_DIVIDER_SELECT_LSB]   = clock_divider_select_ff;
        nxt_rdata[`SACS_REFERENCE_SELECT_MSB:`SACS_REFERENCE_SELECT_LSB] = ref_buf_ff;
      end
      `SACS_IDX_CONTROL_REGISTER_D: begin
        nxt_rdata[SDLY_W-1:0] = sdly_ff;
      end
      `SACS_IDX_SAMPLE_CONTROL_REGISTER: begin
        nxt_rdata[SLEN_W-1:0] = slen_ff;
      end
      `SACS_IDX_CHANSEL: begin
        nxt_rdata[CHAN_W-1:0] = chan_buf_ff;
      end
      `SACS_IDX_COMMAND: begin
        // R1 reads 1 for the whole conversion
        nxt_rdata[`SACS_START_BIT] = start_ff;
      end
      `SACS_IDX_EVENT_CONTROL_REGISTER: begin
        nxt_rdata[`SACS_START_EVENT_INPUT_ENABLE_BIT] = start_event_input_enable_ff;
      end
      `SACS_IDX_INTEN: begin
        nxt_rdata[`SACS_RDYEN_BIT] = rdy_en_ff;
      end
      `SACS_IDX_INTERRUPT_FLAGS_REGISTER: begin
        nxt_rdata[`SACS_RDY_BIT] = rdy_ff;
      end
      `SACS_IDX_RESULT: begin
        // R23 right adjusted
        nxt_rdata[RES_W-1:0] = result_ff;
      end
      `SACS_IDX_STATUS: begin
        nxt_rdata[`SACS_ST_CONV_BIT] = in_conv;
        nxt_rdata[`SACS_ST_ACHAN_LSB +: CHAN_W] = chan_active;
        nxt_rdata[`SACS_ST_AREF_LSB +: REF_W]   = ref_active;
      end
      default: begin
        nxt_rdata = `SACS_RST_WORD;
      end
    endcase
  end

  // Bus slave: one wait cycle, read data captured when waitrequest drops
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      waitrequest <= 1'b1;
      readdata    <= `SACS_RST_WORD;
    end else if (ce) begin
      if ((read || write) && waitrequest) begin
        waitrequest <= 1'b0;
        readdata    <= nxt_rdata;
      end else begin
        waitrequest <= 1'b1;
      end
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      enable_ff   <= 1'b0;
      freerun_ff  <= 1'b0;
      clock_divider_select_ff    <= `SACS_RST_CLOCK_DIVIDER_SELECT;
      ref_buf_ff  <= `SACS_RST_REFERENCE_SELECT;
      chan_buf_ff <= `SACS_RST_CHAN;
      sdly_ff     <= {SDLY_W{1'b0}};
      slen_ff     <= {SLEN_W{1'b0}};
      start_event_input_enable_ff  <= 1'b0;
      rdy_en_ff   <= 1'b0;
    end else if (wr_acc) begin
      case (address)
        `SACS_IDX_CONTROL_REGISTER_A: begin
          enable_ff  <= writedata[`SACS_ENABLE_BIT];
          freerun_ff <= writedata[`SACS_FREERUN_BIT];
        end
        `SACS_IDX_CONTROL_REGISTER_C: begin
          clock_divider_select_ff <= writedata[`SACS_CLOCK_DIVIDER_SELECT_MSB:`SACS_CLOCK_DIVIDER_SELECT_LSB];
          // R16 R20 buffered reference: 0 internal, otherwise supply
          ref_buf_ff <= writedata[`SACS_REFERENCE_SELECT_MSB:`SACS_REFERENCE_SELECT_LSB];
        end
        `SACS_IDX_CONTROL_REGISTER_D: begin
          sdly_ff <= writedata[SDLY_W-1:0];
        end
        `SACS_IDX_SAMPLE_CONTROL_REGISTER: begin
          slen_ff <= writedata[SLEN_W-1:0];
        end
        `SACS_IDX_CHANSEL: begin
          // R16 buffer writable at any time
          chan_buf_ff <= writedata[CHAN_W-1:0];
        end
        `SACS_IDX_EVENT_CONTROL_REGISTER: begin
          start_event_input_enable_ff <= writedata[`SACS_START_EVENT_INPUT_ENABLE_BIT];
        end
        `SACS_IDX_INTEN: begin
          rdy_en_ff <= writedata[`SACS_RDYEN_BIT];
        end
        default: begin
          rdy_en_ff <= rdy_en_ff;
        end
      endcase
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff      <= S_IDLE;
      div_cnt_ff    <= 8'h00;
      cyc_ff        <= 6'h00;
      start_ff      <= 1'b0;
      event_prev_ff <= 1'b0;
      conv_clk      <= 1'b0;
    end else if (ce) begin
      state_ff      <= nxt_state;
      event_prev_ff <= event_in;
      // R10 R11 counter held at zero when disabled or idle
      if (!div_run || (div_cnt_ff == full_m1)) begin
        div_cnt_ff <= 8'h00;
      end else begin
        div_cnt_ff <= div_cnt_ff + 8'h01;
      end
      conv_clk <= div_run & (div_cnt_ff >= half_m1) & (div_cnt_ff != full_m1);
      // R12 count converter cycles from the start edge
      if (tick && (state_ff == S_WAIT || done)) begin
        cyc_ff <= 6'h00;
      end else if (in_conv && tick) begin
        cyc_ff <= cyc_ff + 6'h01;
      end
      // R1 R8 set by software or event; R2 cleared at completion
      if (!enable_ff) begin
        start_ff <= 1'b0;
      end else if (accept) begin
        start_ff <= 1'b1;
      end else if (done && !freerun_ff) begin
        start_ff <= 1'b0;
      end
    end
  end

  // Successive approximation against the external comparator
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dac_code     <= {RES_W{1'b0}};
      mask_ff      <= {RES_W{1'b0}};
      result_ff    <= {RES_W{1'b0}};
      sample_track <= 1'b0;
    end else if (ce) begin
      // R13 R15 track from start, hold after the sampling period
      // Follows the next state so the hold falls on the edge that loads the first trial code
      sample_track <= (nxt_state == S_CONV)
                    & (tick ? (state_ff == S_WAIT || done || cyc_ff + 6'h01 < samp_end)
                            : sample_track);
      if (in_conv && tick && (cyc_ff == samp_end - 6'h01)) begin
        dac_code <= `SACS_SAR_MSB_MASK;
        mask_ff  <= `SACS_SAR_MSB_MASK;
      end else if (bit_step) begin
        // R19 comparator always high walks every bit to 1
        dac_code <= (cmp_in ? dac_code : (dac_code & ~mask_ff)) | (mask_ff >> 1);
        mask_ff  <= mask_ff >> 1;
      end
      // R14 result latched at completion
      if (done) begin
        result_ff <= dac_code;
      end
    end
  end

  // Flag, interrupt and active selections
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdy_ff      <= 1'b0;
      irq         <= 1'b0;
      chan_active <= `SACS_RST_CHAN;
      ref_active  <= `SACS_RST_REFERENCE_SELECT;
    end else if (ce) begin
      // R4 R6 R9 set on every completion, set beats clear
      if (done) begin
        rdy_ff <= 1'b1;
      end else if (rdy_clr) begin
        rdy_ff <= 1'b0;
      end
      // R5 gated request
      irq <= (done | (rdy_ff & ~rdy_clr)) & rdy_en_ff & global_int_en;
      // R3 R16 R17 R22 follow buffers only when enabled and unlocked
      if (enable_ff && !lock_sel) begin
        chan_active <= chan_buf_ff;
        ref_active  <= ref_buf_ff;
      end
    end
  end
endmodule
`default_nettype wire

// [verif/sacs_seq_properties.sv]
`timescale 1ns/1ns
`default_nettype none
`include "sacs_regs.vh"

module sacs_seq_properties #(
  parameter RES_W  = 10,
  parameter CHAN_W = 4,
  parameter REF_W  = 2
) (
  input wire logic              clk,
  input wire logic              nrst,
  input wire logic              ce,
  input wire logic [3:0]        address,
  input wire logic              read,
  input wire logic              write,
  input wire logic [31:0]       writedata,
  input wire logic [31:0]       readdata,
  input wire logic              waitrequest,
  input wire logic              global_int_en,
  input wire logic              irq,
  input wire logic              sample_track,
  input wire logic [RES_W-1:0]  dac_code,
  input wire logic [CHAN_W-1:0] chan_active,
  input wire logic [REF_W-1:0]  ref_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_req;
    (read || write) && waitrequest && ce;
  endsequence
  sequence s_ack;
    !waitrequest ##1 waitrequest;
  endsequence
  sequence s_clr_rd;
    read && !waitrequest && address == `SACS_IDX_RESULT;
  endsequence
  sequence s_clr_wr;
    write && !waitrequest && address == `SACS_IDX_INTERRUPT_FLAGS_REGISTER && writedata[0];
  endsequence

  a_bus_answer: assert property (s_req |=> s_ack)
    else $error("bus answer late or too long");
  a_no_answer: assert property (waitrequest && !(read || write) |=> waitrequest)
    else $error("answer without request");
  a_rdata_hold: assert property (waitrequest |-> $stable(readdata))
    else $error("read data moved outside answer");
  a_irq_gated: assert property (irq |-> $past(global_int_en))
    else $error("irq without global enable");
  a_sel_frozen: assert property (sample_track && $past(sample_track) |->
    $stable(chan_active) && $stable(ref_active))
    else $error("selection moved while sampling");
  a_dac_hold: assert property (sample_track && $past(sample_track) |-> $stable(dac_code))
    else $error("trial code moved while sampling");
  a_read_clear: assert property (s_clr_rd |-> ##[1:2] !irq)
    else $error("result read did not clear flag");
  a_write_clear: assert property (s_clr_wr |-> ##[1:2] !irq)
    else $error("write one did not clear flag");
endmodule

bind sacs_seq sacs_seq_properties #(
  .RES_W(RES_W),
  .CHAN_W(CHAN_W),
  .REF_W(REF_W)
) i_props (
  .clk, .nrst, .ce, .address, .read, .write, .writedata, .readdata, .waitrequest,
  .global_int_en, .irq, .sample_track, .dac_code, .chan_active, .ref_active
);
`default_nettype wire

// [verif/sacs_afe.sv]
`timescale 1ns/1ns
`default_nettype none

module sacs_afe (
  input  wire logic [9:0]  dac_code,
  input  wire logic [10:0] level_x2,
  output logic             cmp_in
);
  // comparator high when the input is above the trial code
  // Level in half steps so every code has a clean midpoint
  assign cmp_in = level_x2 > {dac_code, 1'b0};
endmodule
`default_nettype wire

// [verif/sacs_seq_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`include "sacs_regs.vh"

module sacs_seq_tb;
  localparam int FACTOR = 8;
  logic        clk;
  logic        nrst;
  logic        ce;
  logic [3:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        event_in;
  logic        global_int_en;
  logic        cmp_in;
  logic        irq;
  logic        conv_clk;
  logic        sample_track;
  logic [9:0]  dac_code;
  logic [3:0]  chan_active;
  logic [1:0]  ref_active;
  logic [10:0] level_x2;
  logic [31:0] rd_val;
  int          fails;
  int          compares;
  int          n1;
  int          n2;
  int          r1;
  int          r2;

  sacs_seq i_dut (
    .clk, .nrst, .ce, .address, .read, .write, .writedata, .readdata,
    .waitrequest, .event_in, .global_int_en, .cmp_in, .irq, .conv_clk,
    .sample_track, .dac_code, .chan_active, .ref_active
  );
  sacs_afe i_afe (.dac_code, .level_x2, .cmp_in);

  always #50 clk = ~clk;

  task automatic give_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Extra idle edge keeps a strobe from being driven twice in one step
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    rd_val = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 20) begin
      fails++;
      give_verdict();
    end
    @(posedge clk);
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    do begin
      acc(1'b0, `SACS_IDX_INTERRUPT_FLAGS_REGISTER, 32'h0);
      n++;
    end while (rd_val[0] !== 1'b1 && n < 400);
    if (n >= 400) begin
      fails++;
      give_verdict();
    end
  endtask

  task automatic measure(output int n, output int r);
    logic prev;
    acc(1'b1, `SACS_IDX_COMMAND, 32'h1);
    n = 0;
    r = 0;
    prev = conv_clk;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
      // Converter-clock rising edges, the start edge included
      if (conv_clk === 1'b1 && prev !== 1'b1) begin
        r++;
      end
      prev = conv_clk;
    end
    if (n >= 3000) begin
      fails++;
      give_verdict();
    end
    acc(1'b1, `SACS_IDX_INTERRUPT_FLAGS_REGISTER, 32'h1);
  endtask

  task automatic pulse;
    event_in <= 1'b1;
    @(posedge clk);
    event_in <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    ce = 1'b1;
    address = 4'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    event_in = 1'b0;
    global_int_en = 1'b1;
    level_x2 = 11'h2ab;
    fails = 0;
    compares = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    acc(1'b1, 4'hb, 32'hffff_ffff);
    for (int a = 0; a < 16; a++) begin
      acc(1'b0, a[3:0], 32'h0);
      chk("reset word", 32'h0, rd_val);
    end
    acc(1'b1, `SACS_IDX_CHANSEL, 32'h5);
    repeat (2) @(posedge clk);
    chk("chan disabled", 32'h0, {28'h0, chan_active});
    acc(1'b1, `SACS_IDX_CONTROL_REGISTER_C, 32'h12);
    acc(1'b1, `SACS_IDX_CONTROL_REGISTER_A, 32'h1);
    repeat (2) @(posedge clk);
    chk("chan active", 32'h5, {28'h0, chan_active});
    chk("ref active", 32'h1, {30'h0, ref_active});
    acc(1'b1, `SACS_IDX_COMMAND, 32'h1);
    acc(1'b0, `SACS_IDX_COMMAND, 32'h0);
    chk("start bit", 32'h1, rd_val);
    acc(1'b1, `SACS_IDX_COMMAND, 32'h0);
    acc(1'b0, `SACS_IDX_COMMAND, 32'h0);
    chk("start kept", 32'h1, rd_val);
    repeat (FACTOR) @(posedge clk);
    acc(1'b1, `SACS_IDX_CHANSEL, 32'h7);
    chk("chan held", 32'h5, {28'h0, chan_active});
    wait_done();
    chk("irq off", 32'h0, {31'h0, irq});
    acc(1'b0, `SACS_IDX_COMMAND, 32'h0);
    chk("start cleared", 32'h0, rd_val);
    acc(1'b0, `SACS_IDX_RESULT, 32'h0);
    chk("result", 32'h155, rd_val);
    acc(1'b0, `SACS_IDX_INTERRUPT_FLAGS_REGISTER, 32'h0);
    chk("flag read clear", 32'h0, rd_val);
    chk("chan follows", 32'h7, {28'h0, chan_active});
    acc(1'b1, `SACS_IDX_INTEN, 32'h1);
    level_x2 <= 11'h7ff;
    measure(n1, r1);
    chk("conv time", 32'h1, {31'h0, n1 >= 13 * FACTOR && n1 <= 14 * FACTOR + 8});
    chk("conv clocks", 32'h0e, r1);
    acc(1'b0, `SACS_IDX_INTERRUPT_FLAGS_REGISTER, 32'h0);
    chk("flag write clear", 32'h0, rd_val);
    acc(1'b0, `SACS_IDX_RESULT, 32'h0);
    chk("over reference", 32'h3ff, rd_val);
    acc(1'b1, `SACS_IDX_CONTROL_REGISTER_D, 32'h3);
    acc(1'b1, `SACS_IDX_SAMPLE_CONTROL_REGISTER, 32'h2);
    measure(n2, r2);
    chk("sample extension", 5 * FACTOR, n2 - n1);
    chk("sampled clocks", 32'h13, r2);
    global_int_en <= 1'b0;
    pulse();
    acc(1'b0, `SACS_IDX_COMMAND, 32'h0);
    chk("event ignored", 32'h0, rd_val);
    acc(1'b1, `SACS_IDX_EVENT_CONTROL_REGISTER, 32'h1);
    level_x2 <= 11'h0f5;
    pulse();
    acc(1'b0, `SACS_IDX_COMMAND, 32'h0);
    chk("event start", 32'h1, rd_val);
    // Longer than a whole conversion, so a frozen block must still be busy
    ce <= 1'b0;
    repeat (200) @(posedge clk);
    ce <= 1'b1;
    acc(1'b0, `SACS_IDX_COMMAND, 32'h0);
    chk("start frozen", 32'h1, rd_val);
    wait_done();
    chk("irq gated", 32'h0, {31'h0, irq});
    global_int_en <= 1'b1;
    repeat (2) @(posedge clk);
    chk("irq raised", 32'h1, {31'h0, irq});
    acc(1'b0, `SACS_IDX_RESULT, 32'h0);
    chk("event result", 32'h7a, rd_val);
    acc(1'b1, `SACS_IDX_EVENT_CONTROL_REGISTER, 32'h0);
    acc(1'b1, `SACS_IDX_CONTROL_REGISTER_A, 32'h3);
    acc(1'b1, `SACS_IDX_COMMAND, 32'h1);
    wait_done();
    acc(1'b0, `SACS_IDX_RESULT, 32'h0);
    wait_done();
    acc(1'b0, `SACS_IDX_COMMAND, 32'h0);
    chk("free run start", 32'h1, rd_val);
    acc(1'b1, `SACS_IDX_CONTROL_REGISTER_A, 32'h0);
    acc(1'b0, `SACS_IDX_COMMAND, 32'h0);
    chk("disable stops", 32'h0, rd_val);
    give_verdict();
  end
endmodule
`default_nettype wire
